// ---- down_timer_pwm_tone.sv ----
// Purpose: 10-bit down timer with prescaler, pulse output and tone output
// Assumes: instr_clk_tick is a pclk-domain strobe; pins are asynchronous
// Notes:   Half-step extension is one pclk, the finest step available
//
// Overview of operation
// R1: Counter is 10 bits, counts down on selected source after prescaler.
// R2: Upper reload bits staged first; low byte commits; loads at underflow.
// R3: Low reload byte write while stopped loads the counter at once.
// R4: Reading the count location returns the live count.
// R5: Run enable bit starts and stops counting.
// R6: Fast oscillator select wins; else external pin or instruction clock.
// R7: External pin counts on falling edge if edge bit set, else rising.
// R8: Prescaler active when enable_n is 0; ratio 1:2 to 1:256.
// R9: Prescaler count is readable through its own register.
// R10: Single-pass mode counts down once to zero, underflows, then stops.
// R11: Continuous mode restarts from reload value or 0x3ff per reload bit.
// R12: Underflow sets flag; request when flag enable and global enable set.
// R13: Flag stays set until software writes zero to it.
// R14: Pulse enable drives the shared pin and forces it to output.
// R15: Polarity bit set makes the pulse active low.
// R16: Duty is 10 bits; 0 never active, 0x3ff active 1023 input clocks.
// R17: Software keeps duty no greater than the reload value.
// R18: Upper duty bits staged first; low byte commits; active at wrap.
// R19: Fast oscillator source with half-step bit lengthens the pulse.
// R20: Tone enable drives the shared pin and forces it to output.
// R21: Tone divides prescaler or counter output, ratio 1:2 to 1:256.
// R22: Select codes 0 to 7 give ratios 2,4,8,...,256.
// R23: Pulse output has priority over tone on the shared pin.
`timescale 1ns/1ps
module down_timer_pwm_tone (
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic [31:0]      prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic        instr_clk_tick,
	input  wire logic        external_count_input,
	input  wire logic        internal_fast_osc,
	input  wire logic        shared_output_pin_in,
	output timer_pkg::pin_drive_s shared_output_pin,
	output logic             irq_request
);
	import timer_pkg::*;

	ctrl_a_s     control_register_a;
	ctrl_b_s     control_register_b;
	logic [7:0]  upper_bits_register;
	logic [9:0]  reload_buf;
	logic [9:0]  count;
	logic [9:0]  frame_top;
	logic [9:0]  duty_buf;
	logic [9:0]  duty_active;
	logic [7:0]  ps_cnt;
	logic [7:0]  tone_cnt;
	logic        tone_level;
	logic        tone_out_enable;
	logic [3:0]  tone_divide_select;
	logic        underflow_flag;
	logic        underflow_irq_enable;
	logic        global_irq_enable;
	logic        pwm_hold;
	logic [2:0]  ext_sync;
	logic [2:0]  osc_sync;

	// APB decode
	wire access  = psel & penable;
	wire wr      = access & pwrite & pready;
	wire rd_cap  = access & ~pwrite & ~pready;
	wire hit_a   = paddr == ctrl_a_off;
	wire hit_b   = paddr == ctrl_b_off;
	wire hit_up  = paddr == upper_off;
	wire hit_cnt = paddr == count_off;
	wire hit_dut = paddr == duty_off;
	wire hit_ps  = paddr == pscv_off;
	wire hit_irq = paddr == irq_off;
	wire hit_tc  = paddr == tone_c_off;
	wire hit_ts  = paddr == tone_s_off;
	wire mapped  = hit_a | hit_b | hit_up | hit_cnt | hit_dut | hit_ps |
		hit_irq | hit_tc | hit_ts;
	wire wr_a    = wr & hit_a;
	wire wr_low  = wr & hit_cnt;
	wire wr_duty = wr & hit_dut;
	wire wr_irq  = wr & hit_irq;
	wire [9:0] new_reload = {upper_bits_register[5:4], pwdata[7:0]};
	wire [9:0] new_duty   = {upper_bits_register[1:0], pwdata[7:0]};
	wire [7:0] irq_view   = {global_irq_enable, 2'b00, underflow_flag,
		3'b000, underflow_irq_enable};

	wire [31:0] rd_mux =
		hit_a   ? {24'h000000, control_register_a & ctrl_a_mask} :
		hit_b   ? {24'h000000, control_register_b & ctrl_b_mask} :
		hit_up  ? {24'h000000, upper_bits_register} :
		hit_cnt ? {22'h0, count} : // R4
		hit_dut ? {22'h0, duty_active} :
		hit_ps  ? {24'h000000, ps_cnt} : // R9
		hit_irq ? {24'h000000, irq_view} :
		hit_tc  ? {24'h000000, tone_out_enable, 7'h00} :
		hit_ts  ? {28'h0000000, tone_divide_select} : 32'h00000000;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
			prdata  <= 32'h00000000;
		end else begin
			pready  <= access & ~pready;
			pslverr <= access & ~pready & ~mapped;
			if (rd_cap)
				prdata <= rd_mux;
		end
	end

	// Pin synchronisers; stage 0 is read only by stage 1
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ext_sync <= 3'b000;
			osc_sync <= 3'b000;
		end else begin
			ext_sync <= {ext_sync[1:0], external_count_input};
			osc_sync <= {osc_sync[1:0], internal_fast_osc};
		end
	end

	wire ext_rise  = ext_sync[1] & ~ext_sync[2];
	wire ext_fall  = ~ext_sync[1] & ext_sync[2];
	wire osc_rise  = osc_sync[1] & ~osc_sync[2];
	wire ext_tick  = control_register_b.count_edge_select ? ext_fall
		: ext_rise; // R7
	wire src_sel   = control_register_a.fast_osc_select ? osc_rise :
		control_register_b.external_clock_select ? ext_tick :
		instr_clk_tick; // R6
	wire running   = control_register_a.counter_run_enable;
	wire src_tick  = running & src_sel; // R5
	wire ps_on     = ~control_register_b.prescaler_enable_n;
	wire [7:0] ps_mask = 8'((9'h002 << control_register_b.prescale_rate_select)
		- 9'h001); // R22
	wire ps_wrap   = (ps_cnt & ps_mask) == ps_mask;
	wire ps_tick   = ps_on ? (src_tick & ps_wrap) : src_tick; // R8
	wire cnt_tick  = ps_tick; // R1
	wire underflow = cnt_tick & (count == 10'h000);
	wire [9:0] restart = control_register_a.reload_on_underflow ? reload_buf
		: count_max; // R11
	wire one_shot  = control_register_a.single_pass_select;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			ps_cnt <= 8'h00;
		else if (src_tick & ps_on)
			ps_cnt <= ps_cnt + 8'h01; // R8
	end

	// Control registers; single pass clears run after its underflow
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			control_register_a  <= ctrl_a_rst;
			control_register_b  <= ctrl_b_rst;
			upper_bits_register <= 8'h00;
			tone_out_enable     <= 1'b0;
			tone_divide_select  <= 4'h0;
		end else begin
			if (wr_a)
				control_register_a <= pwdata[7:0] & ctrl_a_mask;
			else if (underflow & one_shot)
				control_register_a.counter_run_enable <= 1'b0; // R10
			if (wr & hit_b)
				control_register_b <= pwdata[7:0] & ctrl_b_mask;
			if (wr & hit_up)
				upper_bits_register <= pwdata[7:0] & upper_mask; // R2
			if (wr & hit_tc)
				tone_out_enable <= pwdata[7];
			if (wr & hit_ts)
				tone_divide_select <= pwdata[3:0];
		end
	end

	// Counter, frame top and double buffers
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			reload_buf  <= count_rst;
			count       <= count_rst;
			frame_top   <= count_rst;
			duty_buf    <= count_rst;
			duty_active <= count_rst;
		end else begin
			if (wr_low)
				reload_buf <= new_reload; // R2
			if (wr_duty)
				duty_buf <= new_duty; // R18
			if (wr_low & ~running) begin
				count     <= new_reload; // R3
				frame_top <= new_reload;
			end else if (underflow & ~one_shot) begin
				count       <= restart; // R11
				frame_top   <= restart;
				duty_active <= duty_buf; // R18
			end else if (cnt_tick & (count != 10'h000))
				count <= count - 10'h001; // R1
		end
	end

	// Underflow flag: set wins over the software clear
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			underflow_flag       <= 1'b0;
			underflow_irq_enable <= 1'b0;
			global_irq_enable    <= 1'b0;
			irq_request          <= 1'b0;
		end else begin
			underflow_flag <= underflow | (underflow_flag &
				~(wr_irq & ~pwdata[flag_bit])); // R12 R13
			if (wr_irq) begin
				underflow_irq_enable <= pwdata[ie_bit];
				global_irq_enable    <= pwdata[gie_bit];
			end
			irq_request <= underflow_flag & underflow_irq_enable &
				global_irq_enable; // R12
		end
	end

	// Pulse generator: active for the first duty ticks of each frame
	wire [9:0] elapsed  = frame_top - count;
	wire pwm_raw        = running & (elapsed < duty_active); // R16
	wire half_on        = control_register_a.fast_osc_select &
		control_register_b.half_step_extend;
	wire pwm_active     = pwm_raw | (half_on & pwm_hold); // R19
	wire pwm_level      = pwm_active ^ control_register_a.pulse_active_low;

	// Tone divider
	wire tone_src  = tone_divide_select[3] ? underflow : ps_tick; // R21
	wire [7:0] tone_mask = 8'((9'h001 << tone_divide_select[2:0])
		- 9'h001); // R22
	wire tone_wrap = (tone_cnt & tone_mask) == tone_mask;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tone_cnt   <= 8'h00;
			tone_level <= 1'b0;
			pwm_hold   <= 1'b0;
		end else begin
			pwm_hold <= pwm_raw;
			if (tone_src) begin
				tone_cnt <= tone_cnt + 8'h01;
				if (tone_wrap)
					tone_level <= ~tone_level; // R21
			end
		end
	end

	// Shared pin, pulse first
	wire pulse_en = control_register_a.pulse_out_enable;
	wire pin_en   = pulse_en | tone_out_enable; // R14 R20
	wire pin_lvl  = pulse_en ? pwm_level : tone_level; // R15 R23

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			shared_output_pin <= 2'b00;
		else begin
			shared_output_pin.enable <= pin_en;
			shared_output_pin.level  <= pin_en & pin_lvl;
		end
	end

	sequence s_setup;
		psel & ~penable;
	endsequence
	sequence s_answer;
		##[1:2] (access & pready);
	endsequence
	property p_apb_answer;
		@(posedge pclk) disable iff (!presetn)
		s_setup ##1 (access & ~pready) |-> s_answer;
	endproperty
	a_apb_answer: assert property (p_apb_answer)
		else $error("APB answer late");
	property p_decrement;
		@(posedge pclk) disable iff (!presetn)
		cnt_tick & (count != 10'h000) & ~wr_low |=>
		count == 10'($past(count) - 10'h001);
	endproperty
	a_decrement: assert property (p_decrement) // R1
		else $error("Counter did not decrement");
	property p_stopped_load;
		@(posedge pclk) disable iff (!presetn)
		wr_low & ~running |=> count == $past(new_reload);
	endproperty
	a_stopped_load: assert property (p_stopped_load) // R3
		else $error("Stopped load missing");
	property p_hold_stopped;
		@(posedge pclk) disable iff (!presetn)
		~running & ~wr_low |=> $stable(count);
	endproperty
	a_hold_stopped: assert property (p_hold_stopped) // R5
		else $error("Counter moved while stopped");
	property p_one_shot;
		@(posedge pclk) disable iff (!presetn)
		underflow & one_shot & ~wr_a |=> ~running & (count == 10'h000);
	endproperty
	a_one_shot: assert property (p_one_shot) // R10
		else $error("Single pass did not stop");
	property p_restart;
		@(posedge pclk) disable iff (!presetn)
		underflow & ~one_shot & ~(wr_low & ~running) |=>
		count == $past(restart) && duty_active == $past(duty_buf);
	endproperty
	a_restart: assert property (p_restart) // R11
		else $error("Wrong restart value");
	property p_flag_set;
		@(posedge pclk) disable iff (!presetn)
		underflow |=> underflow_flag ##1 (irq_request ==
		$past(underflow_irq_enable & global_irq_enable));
	endproperty
	a_flag_set: assert property (p_flag_set) // R12
		else $error("Flag or request wrong after underflow");
	property p_flag_sticky;
		@(posedge pclk) disable iff (!presetn)
		underflow_flag & ~(wr_irq & ~pwdata[flag_bit]) |=> underflow_flag;
	endproperty
	a_flag_sticky: assert property (p_flag_sticky) // R13
		else $error("Flag cleared without software");
	property p_pin_enable;
		@(posedge pclk) disable iff (!presetn)
		pin_en |=> shared_output_pin.enable;
	endproperty
	a_pin_enable: assert property (p_pin_enable) // R14 R20
		else $error("Pin not driven");
	property p_priority;
		@(posedge pclk) disable iff (!presetn)
		pulse_en |=> shared_output_pin.level == $past(pwm_level);
	endproperty
	a_priority: assert property (p_priority) // R15 R23
		else $error("Pin not following pulse");
	property p_prescale_step;
		@(posedge pclk) disable iff (!presetn)
		src_tick & ps_on |=> ps_cnt == 8'($past(ps_cnt) + 8'h01);
	endproperty
	a_prescale_step: assert property (p_prescale_step) // R8 R9
		else $error("Prescaler did not advance");
	property p_prescale_hold;
		@(posedge pclk) disable iff (!presetn)
		~(src_tick & ps_on) |=> $stable(ps_cnt);
	endproperty
	a_prescale_hold: assert property (p_prescale_hold) // R8
		else $error("Prescaler moved without a tick");
	property p_tone_toggle;
		@(posedge pclk) disable iff (!presetn)
		tone_src & tone_wrap |=> tone_level != $past(tone_level);
	endproperty
	a_tone_toggle: assert property (p_tone_toggle) // R21
		else $error("Tone did not toggle");
	property p_apb_refuse;
		@(posedge pclk) disable iff (!presetn)
		access & ~pready |=> pready & (pslverr == ~$past(mapped));
	endproperty
	a_apb_refuse: assert property (p_apb_refuse)
		else $error("Error response wrong");
	property p_irq_gate;
		@(posedge pclk) disable iff (!presetn)
		~(underflow_irq_enable & global_irq_enable) |=> ~irq_request;
	endproperty
	a_irq_gate: assert property (p_irq_gate) // R12
		else $error("Request without both enables");
	property p_duty_hold;
		@(posedge pclk) disable iff (!presetn)
		~underflow |=> $stable(duty_active);
	endproperty
	a_duty_hold: assert property (p_duty_hold) // R18
		else $error("Duty changed off the wrap");
	property p_reload_capture;
		@(posedge pclk) disable iff (!presetn)
		wr_low |=> reload_buf == $past(new_reload);
	endproperty
	a_reload_capture: assert property (p_reload_capture) // R2
		else $error("Reload buffer not written");
endmodule

// ---- timer_pkg.sv ----
// Purpose: Shared constants and register layouts for the down timer block
// Assumes: APB with 32-bit data, one aligned word per register
// Notes:   Fields narrower than a word sit in the low bits
package timer_pkg;
	localparam logic [7:0] ctrl_a_off  = 8'h00;
	localparam logic [7:0] ctrl_b_off  = 8'h04;
	localparam logic [7:0] upper_off   = 8'h08;
	localparam logic [7:0] count_off   = 8'h0c;
	localparam logic [7:0] duty_off    = 8'h10;
	localparam logic [7:0] pscv_off    = 8'h14;
	localparam logic [7:0] irq_off     = 8'h18;
	localparam logic [7:0] tone_c_off  = 8'h1c;
	localparam logic [7:0] tone_s_off  = 8'h20;

	localparam int flag_bit = 4;
	localparam int ie_bit   = 0;
	localparam int gie_bit  = 7;

	localparam logic [7:0] ctrl_a_mask = 8'hcf;
	localparam logic [7:0] ctrl_b_mask = 8'h7f;
	localparam logic [7:0] upper_mask  = 8'h33;
	localparam logic [7:0] ctrl_a_rst  = 8'h00;
	localparam logic [7:0] ctrl_b_rst  = 8'h08;
	localparam logic [9:0] count_max   = 10'h3ff;
	localparam logic [9:0] count_rst   = 10'h000;

	typedef struct packed {
		logic       pulse_out_enable;
		logic       pulse_active_low;
		logic [1:0] rsvd;
		logic       fast_osc_select;
		logic       single_pass_select;
		logic       reload_on_underflow;
		logic       counter_run_enable;
	} ctrl_a_s;

	typedef struct packed {
		logic       rsvd;
		logic       half_step_extend;
		logic       external_clock_select;
		logic       count_edge_select;
		logic       prescaler_enable_n;
		logic [2:0] prescale_rate_select;
	} ctrl_b_s;

	typedef struct packed {
		logic       level;
		logic       enable;
	} pin_drive_s;
endpackage

// ---- pin_side_model.sv ----
// Purpose: Far side of the timer: count pin, fast oscillator, pin readback
// Assumes: Edges spaced wide enough for the two-flop synchroniser
// Notes:   A released shared pin reads back the inverse of its last level
`timescale 1ns/1ps
module pin_side_model (
	input  wire logic            pclk,
	input  wire logic            osc_on,
	input  wire timer_pkg::pin_drive_s pin,
	output logic                 external_count_input,
	output logic                 internal_fast_osc,
	output logic                 shared_output_pin_in
);
	import timer_pkg::*;
	logic last;

	initial begin
		external_count_input = 1'b0;
		internal_fast_osc = 1'b0;
		last = 1'b0;
	end

	// Oscillator stands still while not wanted
	always #30 internal_fast_osc <= osc_on ? ~internal_fast_osc : 1'b0;

	always @(posedge pclk) begin
		if (pin.enable) begin
			last <= pin.level;
		end
	end

	assign shared_output_pin_in = pin.enable ? pin.level : ~last;

	// n rising and n falling edges, ending low
	task automatic edges(input int n);
		repeat (2 * n) begin
			repeat (4) @(posedge pclk);
			external_count_input <= ~external_count_input;
		end
		repeat (8) @(posedge pclk);
	endtask
endmodule

// ---- down_timer_pwm_tone_bench.sv ----
// Purpose: Self-checking bench for the down timer over APB
// Assumes: One wait state per access; prescaler off after reset
// Notes:   Prescaler checks use 2*ratio ticks so the phase does not matter
`timescale 1ns/1ps
module down_timer_pwm_tone_bench;
	import timer_pkg::*;
	logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
	logic [7:0]  paddr;
	logic [31:0] pwdata, prdata, rd;
	logic        err, tick, ext_in, osc, pin_in, irq, osc_on;
	logic [7:0]  seen;
	logic        level0;
	pin_drive_s  pin;
	int          bad_count, total_checks, cycles;

	down_timer_pwm_tone dut (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .instr_clk_tick(tick),
		.external_count_input(ext_in), .internal_fast_osc(osc),
		.shared_output_pin_in(pin_in), .shared_output_pin(pin),
		.irq_request(irq));

	pin_side_model peer (.pclk(pclk), .osc_on(osc_on), .pin(pin),
		.external_count_input(ext_in), .internal_fast_osc(osc),
		.shared_output_pin_in(pin_in));

	initial begin
		pclk = 1'b0;
		forever #5 pclk = ~pclk;
	end

	always @(posedge pclk) begin
		cycles++;
		if (cycles == 20000) begin
			bad_count++;
			close_out();
		end
	end

	task automatic close_out;
		$display("Checks %0d, mismatches %0d", total_checks, bad_count);
		if (bad_count == 0 && total_checks > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask

	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp) begin
			bad_count++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic apb(input logic w, input logic [7:0] a,
		input logic [31:0] d);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
		end while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask

	task automatic rdc(input logic [7:0] a, input logic [31:0] e);
		apb(1'b0, a, 32'h0);
		check(rd, e);
	endtask

	task automatic ticks(input int n);
		repeat (n) begin
			tick <= 1'b1;
			@(posedge pclk);
			tick <= 1'b0;
			repeat (2) @(posedge pclk);
		end
		repeat (4) @(posedge pclk);
	endtask

	initial begin
		{presetn, psel, penable, pwrite, tick, osc_on} = 6'h00;
		paddr = 8'h00;
		pwdata = 32'h0;
		repeat (20) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		rdc(ctrl_a_off, 32'h00);
		rdc(ctrl_b_off, 32'h08);
		rdc(count_off, 32'h000);
		apb(1'b0, 8'h40, 32'h0);
		check({err, rd[30:0]}, 32'h80000000);
		// Stopped load of reload high and low parts
		wr(upper_off, 32'h10);
		wr(count_off, 32'h05);
		rdc(count_off, 32'h105);
		wr(upper_off, 32'h00);
		wr(count_off, 32'h03);
		wr(ctrl_a_off, 32'h01);
		ticks(3);
		rdc(count_off, 32'h000);
		ticks(1);
		rdc(count_off, 32'h3ff);
		rdc(irq_off, 32'h10);
		wr(ctrl_a_off, 32'h00);
		ticks(2);
		rdc(count_off, 32'h3ff);
		wr(irq_off, 32'h91);
		@(posedge pclk);
		check(irq, 1'b1);
		rdc(irq_off, 32'h91);
		wr(irq_off, 32'h81);
		@(posedge pclk);
		check(irq, 1'b0);
		// Reload buffer lands only at underflow while running
		wr(count_off, 32'h02);
		wr(ctrl_a_off, 32'h03);
		ticks(3);
		rdc(count_off, 32'h002);
		wr(count_off, 32'h05);
		rdc(count_off, 32'h002);
		ticks(3);
		rdc(count_off, 32'h005);
		wr(ctrl_a_off, 32'h00);
		wr(count_off, 32'h02);
		wr(ctrl_a_off, 32'h05);
		ticks(4);
		rdc(count_off, 32'h000);
		rdc(ctrl_a_off, 32'h04);
		wr(ctrl_b_off, 32'h28);
		wr(count_off, 32'h0a);
		wr(ctrl_a_off, 32'h01);
		peer.edges(3);
		ticks(2);
		rdc(count_off, 32'h007);
		wr(ctrl_b_off, 32'h38);
		peer.edges(2);
		rdc(count_off, 32'h005);
		for (int c = 0; c < 8; c++) begin
			wr(ctrl_a_off, 32'h00);
			wr(ctrl_b_off, c);
			wr(count_off, 32'h14);
			wr(ctrl_a_off, 32'h01);
			ticks(4 << c);
			rdc(count_off, 32'h012);
		end
		apb(1'b0, pscv_off, 32'h0);
		seen = rd[7:0];
		ticks(3);
		rdc(pscv_off, {24'h000000, seen + 8'h03});
		wr(ctrl_a_off, 32'h00);
		wr(ctrl_b_off, 32'h08);
		wr(count_off, 32'h14);
		wr(ctrl_a_off, 32'h09);
		osc_on <= 1'b1;
		repeat (60) @(posedge pclk);
		osc_on <= 1'b0;
		repeat (8) @(posedge pclk);
		apb(1'b0, count_off, 32'h0);
		check(rd[9:0] > 10'd6 && rd[9:0] < 10'd14, 1'b1);
		// Duty frame: reload 4, duty 2, within the frame
		wr(ctrl_a_off, 32'h00);
		wr(count_off, 32'h04);
		wr(duty_off, 32'h02);
		rdc(duty_off, 32'h000);
		wr(ctrl_a_off, 32'h83);
		ticks(5);
		check({pin.enable, pin.level}, 2'b11);
		rdc(duty_off, 32'h002);
		ticks(2);
		check(pin.level, 1'b0);
		wr(tone_c_off, 32'h80);
		wr(ctrl_a_off, 32'hc3);
		@(posedge pclk);
		check(pin.level, 1'b1);
		wr(ctrl_a_off, 32'h83);
		@(posedge pclk);
		check(pin.level, 1'b0);
		wr(ctrl_a_off, 32'h02);
		@(posedge pclk);
		check(pin.enable, 1'b1);
		// Tone from the prescaler path: one toggle per two ticks
		wr(tone_s_off, 32'h01);
		wr(ctrl_a_off, 32'h01);
		level0 = pin.level;
		ticks(2);
		check(pin.level, {31'h0, ~level0});
		// Tone from the counter path: one toggle per underflow
		wr(tone_s_off, 32'h08);
		wr(ctrl_a_off, 32'h00);
		wr(count_off, 32'h01);
		wr(ctrl_a_off, 32'h01);
		level0 = pin.level;
		ticks(2);
		check(pin.level, {31'h0, ~level0});
		close_out();
	end
endmodule
